// ==== design/risa_host.sv ====
// host controller that loads operands and reads results from the alu pins
//
// Operation
// - write: set address, data, pulse strobe low
// - host holds op code bits 3..1 low writing
// - read: set address, op, enable output low
// - host never issues codes 12 to 15
// - strobe and enable idle high
`timescale 1ns/1ps
module risa_host import risa_pkg::*; (
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_cmd_valid,
	output logic             o_cmd_ready,
	input  wire risa_cmd_t   i_cmd,
	output logic             o_rsp_valid,
	output logic [31:0]      o_rsp_data,
	output logic             o_cmd_error,
	output risa_pins_t       o_pins,
	output logic [7:0]       o_data_out,
	output logic             o_data_oe,
	input  wire logic [7:0]  i_data_in,
	input  wire logic [7:0]  i_result
);
	risa_state_t state;
	risa_cmd_t   cmd;
	logic [1:0]  byte_idx;
	logic [31:0] gather;
	logic        load;
	logic        expired;
	logic        last_byte;

	// access walk, pins registered one clock behind the state:
	//   setup  - lane, op code and write data set; enable drops for reads
	//   strobe - write strobe low one clock; read byte taken at its end
	//   hold   - strobe high again with lane and data unchanged, so the
	//            alu latches the byte on the rising strobe edge
	// lanes walk from 0 upward; a done clock after lane 3 raises the answer,
	// so every accepted command runs four lanes of three clocks plus done.
	// enable stays low across all four read lanes: the alu drives the port
	// the whole time and the host never turns it round mid-read.
	// each phase is one clock at 10 MHz; slower pin timing only needs new
	// package counts, at the price of a wider timer for long phases.
	// refused codes never leave idle, so the pins stay quiet for them.

	////////////////////////////////////////////////////////////////////////
	// phase timer
	risa_timer u_timer (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_load     (load),
		.i_count    ((state == ST_SETUP) ? STROBE_CNT : SETUP_CNT),
		.o_expired  (expired)
	);

	assign last_byte   = (byte_idx == BYTE_LAST);
	assign o_cmd_ready = (state == ST_IDLE);
	// reload when entering setup or strobe phase
	assign load = (state == ST_IDLE && i_cmd_valid && o_cmd_ready &&
		!(!i_cmd.write && i_cmd.op_code > OP_LAST_LEGAL)) ||
		(state == ST_SETUP && expired) ||
		(state == ST_HOLD && expired && !last_byte);

	////////////////////////////////////////////////////////////////////////
	// sequencer
	// one command at a time; ready is simply the idle state, so a new
	// command is taken once the done clock has passed.
	// hold loops back to setup until lane 3 is finished
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			state <= ST_IDLE;
		end else begin
			case (state)
				ST_IDLE:   if (load) state <= ST_SETUP;
				ST_SETUP:  if (expired) state <= ST_STROBE;
				ST_STROBE: if (expired) state <= ST_HOLD;
				ST_HOLD:   if (expired) state <= last_byte ? ST_DONE : ST_SETUP;
				ST_DONE:   state <= ST_IDLE;
				default:   state <= ST_IDLE;
			endcase
		end
	end

	// command latch and byte walk
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			cmd      <= '0;
			byte_idx <= 2'h0;
		end else if (state == ST_IDLE && load) begin
			cmd      <= i_cmd;
			byte_idx <= 2'h0;
		end else if (state == ST_HOLD && expired && !last_byte) begin
			byte_idx <= byte_idx + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins: registered so strobes never glitch
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_pins     <= '{byte_sel: 2'h0, op_code: 4'h0, oe_n: 1'b1, we_n: 1'b1};
			o_data_out <= 8'h00;
			o_data_oe  <= 1'b0;
		end else begin
			o_pins.byte_sel <= byte_idx;
			o_pins.op_code  <= cmd.write ? {3'h0, cmd.operand} : cmd.op_code;
			o_pins.we_n     <= !(cmd.write && state == ST_STROBE);
			o_pins.oe_n     <= !(!cmd.write && (state == ST_SETUP ||
				state == ST_STROBE || state == ST_HOLD));
			o_data_oe       <= cmd.write && (state == ST_SETUP ||
				state == ST_STROBE || state == ST_HOLD);
			o_data_out      <= cmd.data[8*byte_idx +: 8];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// gather read bytes at end of strobe phase
	// the port is sampled only with enable low, never as a released bus
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			gather <= RESULT_RST;
		end else if (state == ST_STROBE && expired && !cmd.write) begin
			gather[8*byte_idx +: 8] <= i_data_in;
		end
	end

	// answer
	// refusal is flagged one clock after the refused edge and the
	// sequencer never leaves idle, so ready stays high for the next one
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			o_rsp_valid <= 1'b0;
			o_rsp_data  <= RESULT_RST;
			o_cmd_error <= 1'b0;
		end else begin
			o_rsp_valid <= (state == ST_DONE);
			if (state == ST_DONE && !cmd.write) begin
				o_rsp_data <= gather;
			end
			o_cmd_error <= (state == ST_IDLE && i_cmd_valid && !i_cmd.write &&
				i_cmd.op_code > OP_LAST_LEGAL);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	// every assertion samples the core clock and sleeps while reset holds
	// the pins idle; strobe lines are checked as the alu would see them
	// strobes never both low
	strobe_excl_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!(!o_pins.we_n && !o_pins.oe_n)) else $error("strobe and enable both low");
	// write keeps upper op bits low
	write_opbits_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_pins.we_n |-> o_pins.op_code[3:1] == 3'h0) else $error("op bits high in write");
	write_data_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_pins.we_n) |-> $past(o_data_oe) && o_data_oe ##1 o_data_oe)
		else $error("data not held round strobe");
	illegal_op_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_pins.oe_n |-> o_pins.op_code <= OP_LAST_LEGAL) else $error("illegal op on pins");
	read_done_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_cmd_ready && i_cmd_valid |-> ##[1:14] o_cmd_ready) else $error("command hung");
	// bus released and strobes high in idle
	idle_quiet_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state == ST_IDLE |-> o_pins.we_n && o_pins.oe_n && !o_data_oe)
		else $error("pins active while idle");
	// host never drives while the alu does
	bus_fight_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_pins.oe_n |-> !o_data_oe) else $error("port driven from both ends");
	strobe_width_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_pins.we_n) |=> $rose(o_pins.we_n)) else $error("write strobe width");
	// lane, op and data steady under strobe
	write_steady_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		!o_pins.we_n |-> $stable(o_pins.byte_sel) && $stable(o_pins.op_code) &&
		$stable(o_data_out)) else $error("write lane moved under strobe");
	// read byte taken on its own lane
	read_lane_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		state == ST_STROBE && expired && !cmd.write |->
		!o_pins.oe_n && o_pins.byte_sel == byte_idx) else $error("read sampled off lane");
	refuse_idle_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_cmd_error |-> state == ST_IDLE && o_cmd_ready) else $error("refused command ran");
	// enable low across all four lanes
	oe_span_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$fell(o_pins.oe_n) |-> ##12 $rose(o_pins.oe_n)) else $error("read enable span");
	// data drive spans all four lanes
	drive_span_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		$rose(o_data_oe) |-> ##12 $fell(o_data_oe)) else $error("write drive span");
	// answer strobe lasts one clock
	done_pulse_a: assert property (@(posedge i_core_clk) disable iff (i_rst)
		o_rsp_valid |=> !o_rsp_valid) else $error("answer longer than one clock");
	// main scenarios
	cover_write_c: cover property (@(posedge i_core_clk) o_rsp_valid && cmd.write);
	cover_read_c: cover property (@(posedge i_core_clk) o_rsp_valid && !cmd.write);
	cover_error_c: cover property (@(posedge i_core_clk) o_cmd_error);
	cover_maskpack_c: cover property (@(posedge i_core_clk)
		o_rsp_valid && !cmd.write && cmd.op_code == OP_MASKPACK_FULL);
	// dedicated outputs agree with the port during a read
	cover_lane_c: cover property (@(posedge i_core_clk)
		state == ST_STROBE && !cmd.write && i_result == i_data_in);
endmodule : risa_host

// ==== design/risa_pkg.sv ====
// package for the host-side controller of the rotate/interleave/select alu
package risa_pkg;
	// operation codes
	localparam logic [3:0] OP_FIRST          = 4'h0;
	localparam logic [3:0] OP_SECOND         = 4'h1;
	localparam logic [3:0] OP_ROTCONJ_HALF   = 4'h2;
	localparam logic [3:0] OP_ROTCONJ_FULL   = 4'h3;
	localparam logic [3:0] OP_ROTDISJ_HALF   = 4'h4;
	localparam logic [3:0] OP_ROTDISJ_FULL   = 4'h5;
	localparam logic [3:0] OP_ROTPAR_HALF    = 4'h6;
	localparam logic [3:0] OP_ROTPAR_FULL    = 4'h7;
	localparam logic [3:0] OP_INTERLEAVE_LO  = 4'h8;
	localparam logic [3:0] OP_INTERLEAVE_HI  = 4'h9;
	localparam logic [3:0] OP_MASKPACK_HALF  = 4'ha;
	localparam logic [3:0] OP_MASKPACK_FULL  = 4'hb;
	localparam logic [3:0] OP_LAST_LEGAL     = 4'hb;
	// pin timing, in ns, and derived cycle counts at 10 MHz
	localparam int CLK_PERIOD_NS   = 100;
	localparam int SETUP_NS        = 100;
	localparam int STROBE_NS       = 100;
	localparam int SETUP_CYC       = (SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC      = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [1:0] SETUP_CNT  = 2'(SETUP_CYC);
	localparam logic [1:0] STROBE_CNT = 2'(STROBE_CYC);
	localparam logic [1:0] BYTE_LAST  = 2'h3;
	localparam logic [31:0] RESULT_RST = 32'h0000_0000;

	// host command
	typedef struct packed {
		logic        write;     // 1 = load operand, 0 = read result
		logic        operand;   // write: 0 first, 1 second
		logic [3:0]  op_code;   // read: operation
		logic [31:0] data;      // write: whole word
	} risa_cmd_t;

	// pins toward the alu
	typedef struct packed {
		logic [1:0] byte_sel;
		logic [3:0] op_code;
		logic       oe_n;
		logic       we_n;
	} risa_pins_t;

	typedef enum logic [2:0] {
		ST_IDLE   = 3'b000,
		ST_SETUP  = 3'b001,
		ST_STROBE = 3'b010,
		ST_HOLD   = 3'b011,
		ST_DONE   = 3'b100
	} risa_state_t;
endpackage : risa_pkg

// ==== design/risa_timer.sv ====
// small down-counter timing each pin phase
`timescale 1ns/1ps
module risa_timer import risa_pkg::*; (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst,
	input  wire logic       i_load,
	input  wire logic [1:0] i_count,
	output logic            o_expired
);
	logic [1:0] count;

	// reload on setup and strobe entry, count down to zero
	always_ff @(posedge i_core_clk or posedge i_rst) begin
		if (i_rst) begin
			count <= 2'h0;
		end else if (i_load) begin
			count <= i_count;
		end else if (count != 2'h0) begin
			count <= count - 2'h1;
		end
	end

	// expired leans only on the count, never on i_load: the sequencer feeds
	// expired back into i_load, so an i_load term would close a loop.
	// a phase loaded with n lasts n clocks; an unloaded phase lasts one
	assign o_expired = (count <= 2'h1);
endmodule : risa_timer

// ==== test/risa_alu_model.sv ====
// behavioural model of the alu as seen at its pins
`timescale 1ns/1ps
module risa_alu_model import risa_pkg::*; (
	input  wire risa_pins_t i_pins,
	input  wire logic [7:0] i_bus,
	output logic [7:0]      o_result,
	output logic            o_drive
);
	logic [31:0] first, second, u, r;
	logic [3:0]  op;
	int          j;
	assign op = i_pins.op_code;
	always @(posedge i_pins.we_n) begin
		if (op[0]) second[8*i_pins.byte_sel +: 8] <= i_bus;
		else first[8*i_pins.byte_sel +: 8] <= i_bus;
	end
	always_comb begin
		u = op[0] ? {first[0], first[31:1]} : {first[16], first[31:17], first[0], first[15:1]};
		r = 32'h0; // codes 12..15 read as zero here
		j = 0;
		case (op)
			4'h0, 4'h1: r = op[0] ? second : first;
			4'h2, 4'h3: r = first & u;
			4'h4, 4'h5: r = first | u;
			4'h6, 4'h7: r = first ^ u;
			4'h8, 4'h9: for (int i = 0; i < 16; i++) r[2*i +: 2] = {first[16*op[0]+i], second[16*op[0]+i]};
			4'ha, 4'hb: for (int i = 0; i < 32; i++) begin
				if (i == 16 && !op[0]) j = 16;
				if (second[i]) begin
					r[j] = first[i];
					j++;
				end
			end
			default: ;
		endcase
	end
	// addressed byte, bus driven while enable low
	assign o_result = r[8*i_pins.byte_sel +: 8];
	assign o_drive  = !i_pins.oe_n;
endmodule : risa_alu_model

// ==== test/risa_host_tb.sv ====
// self-checking bench for the host-side alu controller
`timescale 1ns/1ps
module risa_host_tb import risa_pkg::*; ;
	typedef struct packed {logic err; logic wr; logic [31:0] data;} risa_note_t;
	logic        i_core_clk, i_rst, i_cmd_valid, o_cmd_ready, o_rsp_valid, o_cmd_error, o_data_oe, drv;
	logic [31:0] o_rsp_data, a, b;
	logic [7:0]  o_data_out, bus, last, res;
	risa_cmd_t   i_cmd;
	risa_pins_t  o_pins;
	risa_note_t  q[$], n;
	int          error_cnt = 0, cmp_count = 0;
	risa_host DUT (.i_core_clk, .i_rst, .i_cmd_valid, .o_cmd_ready, .i_cmd, .o_rsp_valid, .o_rsp_data,
		.o_cmd_error, .o_pins, .o_data_out, .o_data_oe, .i_data_in(bus), .i_result(res));
	risa_alu_model alu (.i_pins(o_pins), .i_bus(bus), .o_result(res), .o_drive(drv));
	// released bus shows the inverse of its last level, so stale reads fail
	assign bus = o_data_oe ? o_data_out : (drv ? res : ~last);
	always @(posedge i_core_clk) last <= bus;
	initial begin
		i_core_clk = 1'b0;
		forever #50 i_core_clk = ~i_core_clk;
	end
	task automatic chk(input logic ok, input string what);
		cmp_count++;
		if (!ok) begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, what);
		end
	endtask : chk
	task automatic chk_data(input logic [31:0] got, exp);
		chk(got === exp, $sformatf("result %h expected %h", got, exp));
	endtask : chk_data
	// independent bit-loop reference of every legal code
	function automatic logic [31:0] ref_op(input logic [3:0] op, input logic [31:0] a, b);
		logic [31:0] r;
		int          j, k, w;
		r = '0;
		w = op[0] ? 32 : 16;
		for (int i = 0; i < 32; i++) begin
			k = (i % w == w - 1) ? i - w + 1 : i + 1;
			if (i % w == 0) j = i;
			case (op[3:1])
				3'd0: r[i] = op[0] ? b[i] : a[i];
				3'd1: r[i] = a[i] & a[k];
				3'd2: r[i] = a[i] | a[k];
				3'd3: r[i] = a[i] ^ a[k];
				3'd4: r[i] = i % 2 ? a[16*op[0]+i/2] : b[16*op[0]+i/2];
				default: if (b[i]) begin
					r[j] = a[i];
					j++;
				end
			endcase
		end
		return r;
	endfunction : ref_op
	task automatic send(input logic w, s, input logic [3:0] op, input logic [31:0] d, e);
		i_cmd_valid <= 1'b1;
		i_cmd       <= '{write: w, operand: s, op_code: op, data: d};
		q.push_back('{err: !w && op > OP_LAST_LEGAL, wr: w, data: e});
		@(negedge i_core_clk);
		while (o_cmd_ready !== 1'b1) @(negedge i_core_clk);
		@(posedge i_core_clk);
	endtask : send
	task automatic end_of_test();
		$display("compares %0d errors %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test
	// response watcher takes the oldest note
	always @(negedge i_core_clk) if (o_rsp_valid === 1'b1 || o_cmd_error === 1'b1) begin
		chk(q.size() > 0, "unexpected response");
		n = q.pop_front();
		chk(o_cmd_error === n.err, "refusal flag");
		chk(o_pins.oe_n === 1'b1 && o_pins.we_n === 1'b1, "strobes not idle");
		if (!n.err && !n.wr) chk_data(o_rsp_data, n.data);
	end
	always @(negedge o_pins.we_n) chk(o_pins.op_code[3:1] === 3'h0, "write op bits");
	initial begin
		#1_000_000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		void'($urandom(59240));
		i_rst = 1'b1;
		i_cmd_valid = 1'b0;
		i_cmd = '0;
		last = 8'h00;
		repeat (2) @(posedge i_core_clk);
		i_rst <= 1'b0;
		@(posedge i_core_clk);
		// first pair is the known select pair, then random words, back to back
		for (int t = 0; t < 12; t++) begin
			a = t ? $urandom : 32'h0000_00b3;
			b = t ? $urandom : 32'h0000_00c9;
			send(1'b1, 1'b0, 4'h0, a, 32'h0);
			send(1'b1, 1'b1, 4'h0, b, 32'h0);
			for (int op = 0; op < 12; op++) send(1'b0, 1'b0, 4'(op), $urandom, ref_op(4'(op), a, b));
			send(1'b0, 1'b0, 4'hc + 4'($urandom % 4), 32'h0, 32'h0);
		end
		i_cmd_valid <= 1'b0;
		repeat (30) @(posedge i_core_clk);
		chk(q.size() == 0, "missing responses");
		end_of_test();
	end
endmodule : risa_host_tb
